/* pkg/rgen_map.svh */
// Register map, field positions, reset values and counts of the rate generator.
// Assumes inclusion by bare name from any file that needs it.
`ifndef RGEN_MAP_SVH
`define RGEN_MAP_SVH

// ==========================================================
// Byte offsets on the register bus
`define RGEN_TXSC_OFF    8'h00
`define RGEN_RXSC_OFF    8'h04
`define RGEN_RATE_OFF    8'h08
`define RGEN_DIVH_OFF    8'h0c
`define RGEN_DIVL_OFF    8'h10
`define RGEN_STAT_OFF    8'h14

// ==========================================================
// Field positions
`define RGEN_TXSC_MASTER 7
`define RGEN_TXSC_SYNC   4
`define RGEN_TXSC_HIGH   2
`define RGEN_TXSC_IDLE   1
`define RGEN_RXSC_EN     7
`define RGEN_RATE_IDLE   6
`define RGEN_RATE_WIDE   3
`define RGEN_RATE_UNIMP  2

// ==========================================================
// Reset values and writable masks
`define RGEN_TXSC_RST    8'h02
`define RGEN_RXSC_RST    8'h00
`define RGEN_RATE_RST    8'h40
`define RGEN_DIV_RST     8'h00
`define RGEN_TXSC_WMASK  8'hfd
`define RGEN_RXSC_WMASK  8'hf8
`define RGEN_RATE_WMASK  8'hbb

// ==========================================================
// Prescale counts per mode
`define RGEN_PRE_ASYNC_LOW 7'd64
`define RGEN_PRE_ASYNC_MID 7'd16
`define RGEN_PRE_FAST      7'd4

`endif

/* pkg/rgen_pkg.sv */
// Types shared by the rate generator files.
// Assumes the constants header is compiled alongside.
`default_nettype none
package rgen_pkg;
  typedef enum logic [2:0] {
    RGEN_DIV64 = 3'b001,
    RGEN_DIV16 = 3'b010,
    RGEN_DIV4  = 3'b100
  } rgen_ratio_e;
  typedef logic [15:0] rgen_div_t;
endpackage
`default_nettype wire

/* src/rgen_sampler.sv */
// Receive line sampler: majority of three or a single sample.
// Assumes rx_in is already synchronised to core_clk.
`default_nettype none
module rgen_sampler (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic rx_in,
  input  wire logic sample_tick,
  input  wire logic single_mode,
  output logic      rx_level
);
  logic [2:0] hist_q;
  wire        vote = (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2]) | (hist_q[0] & hist_q[2]);
  wire        pick = single_mode ? hist_q[0] : vote;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q   <= 3'h7;
      rx_level <= 1'b1;
    end else if (sample_tick) begin
      hist_q   <= {hist_q[1:0], rx_in};
      rx_level <= pick;
    end
  end
endmodule
`default_nettype wire

/* src/rgen_top.sv */
// Rate generator for a serial port with an AHB-Lite register slave.
// Assumes one clock core_clk at 125 MHz and a single AHB-Lite master.
//
// Overview of operation
// [R1] The rate is derived from core_clk, so it scales with that clock.
// [R2] Software reprograms the divisor pair when the system clock frequency changes.
// [R3] Without sync mode and without both wide and high speed, receive takes a three-sample majority.
// [R4] With sync mode or with both wide and high speed set, receive uses one sample.
// [R5] Async, 8-bit, low speed gives clock over 64 times divisor plus one.
// [R6] Async 8-bit high speed, or 16-bit low speed, gives clock over 16 times divisor plus one.
// [R7] Sync master, 8-bit, gives clock over 4 times divisor plus one.
// [R8] The divisor is the high byte above the low byte.
// [R9] With the wide select clear only the low byte is used.
// [R10] In sync mode the high speed select has no effect.
// [R11] Any write to a divisor byte reloads the timer at once.
// [R12] The timer is free running, its period set by the divisor, for both modes.
// [R13] Async, 16-bit, high speed gives clock over 4 times divisor plus one.
// [R14] Sync master, 16-bit, uses the divide-by-four formula on the full divisor.
`include "rgen_map.svh"
`default_nettype none
module rgen_top (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_pin,
  output logic             rate_tick,
  output logic             sample_tick,
  output logic             sync_clk,
  output logic             rx_level
);
  // ==========================================================
  // Reset release
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ==========================================================
  // Bus slave: zero wait states
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] transmit_status_control_q;
  logic [7:0] receive_status_control_q;
  logic [7:0] rate_control_q;
  logic [7:0] divisor_high_byte_q;
  logic [7:0] divisor_low_byte_q;

  wire        take     = hsel & hready & htrans[1];
  wire        take_wr  = take & hwrite;
  wire        take_rd  = take & ~hwrite;
  wire [7:0]  wbyte    = hwdata[7:0];
  wire        wr_txsc  = wr_pend_q && (wr_addr_q == `RGEN_TXSC_OFF);
  wire        wr_rxsc  = wr_pend_q && (wr_addr_q == `RGEN_RXSC_OFF);
  wire        wr_rate  = wr_pend_q && (wr_addr_q == `RGEN_RATE_OFF);
  wire        wr_divh  = wr_pend_q && (wr_addr_q == `RGEN_DIVH_OFF);
  wire        wr_divl  = wr_pend_q && (wr_addr_q == `RGEN_DIVL_OFF);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take_wr;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Read-only bits keep their hardware value; masks protect them
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  wire timer_idle;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_status_control_q <= `RGEN_TXSC_RST;
      receive_status_control_q  <= `RGEN_RXSC_RST;
      rate_control_q            <= `RGEN_RATE_RST;
      divisor_high_byte_q       <= `RGEN_DIV_RST;
      divisor_low_byte_q        <= `RGEN_DIV_RST;
    end else begin
      if (wr_txsc) transmit_status_control_q <= merge(transmit_status_control_q, wbyte, `RGEN_TXSC_WMASK);
      if (wr_rxsc) receive_status_control_q  <= merge(receive_status_control_q, wbyte, `RGEN_RXSC_WMASK);
      if (wr_rate) rate_control_q            <= merge(rate_control_q, wbyte, `RGEN_RATE_WMASK);
      if (wr_divh) divisor_high_byte_q       <= wbyte;
      if (wr_divl) divisor_low_byte_q        <= wbyte;
    end
  end

  // Read mux: rate idle and tick status bits show live state; the transmit idle bit reads its stored reset value
  wire [7:0] txsc_rd = transmit_status_control_q;
  wire [7:0] rate_rd = {rate_control_q[7], timer_idle, rate_control_q[5:3], 1'b0, rate_control_q[1:0]};
  wire [7:0] rd_byte =
    (haddr[7:0] == `RGEN_TXSC_OFF) ? txsc_rd :
    (haddr[7:0] == `RGEN_RXSC_OFF) ? receive_status_control_q :
    (haddr[7:0] == `RGEN_RATE_OFF) ? rate_rd :
    (haddr[7:0] == `RGEN_DIVH_OFF) ? divisor_high_byte_q :
    (haddr[7:0] == `RGEN_DIVL_OFF) ? divisor_low_byte_q :
    (haddr[7:0] == `RGEN_STAT_OFF) ? {7'h00, rate_tick} : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) hrdata <= 32'h0000_0000;
    else if (take_rd) hrdata <= {24'h000000, rd_byte};
  end

  // ==========================================================
  // Mode decode
  wire mode_sync   = transmit_status_control_q[`RGEN_TXSC_SYNC];
  wire mode_high   = transmit_status_control_q[`RGEN_TXSC_HIGH];
  wire mode_master = transmit_status_control_q[`RGEN_TXSC_MASTER];
  wire mode_wide   = rate_control_q[`RGEN_RATE_WIDE];
  wire port_en     = receive_status_control_q[`RGEN_RXSC_EN];

  // Divisor pair, high byte masked off in 8-bit mode
  wire [15:0] divisor = {mode_wide ? divisor_high_byte_q : 8'h00, divisor_low_byte_q}; // [R8] [R9]

  rgen_pkg::rgen_ratio_e ratio;
  assign ratio = mode_sync ? rgen_pkg::RGEN_DIV4 :                         // [R7] [R10] [R14]
                 (mode_wide & mode_high) ? rgen_pkg::RGEN_DIV4 :           // [R13]
                 (mode_wide | mode_high) ? rgen_pkg::RGEN_DIV16 :          // [R6]
                 rgen_pkg::RGEN_DIV64;                                     // [R5]

  wire [6:0] pre_len = (ratio == rgen_pkg::RGEN_DIV4)  ? `RGEN_PRE_FAST :
                       (ratio == rgen_pkg::RGEN_DIV16) ? `RGEN_PRE_ASYNC_MID : `RGEN_PRE_ASYNC_LOW;

  // ==========================================================
  // Free-running timer on core_clk; prescaler then divisor counter
  logic [15:0] div_cnt_q;
  logic [6:0]  pre_cnt_q;
  wire         reload  = wr_divh | wr_divl | ~port_en;                      // [R11]
  wire         pre_end = (pre_cnt_q == 7'(pre_len - 7'd1));
  wire         div_end = (div_cnt_q == 16'h0000);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_q <= 7'h00;
      div_cnt_q <= 16'h0000;
      rate_tick <= 1'b0;
    end else if (reload) begin                                              // [R11]
      pre_cnt_q <= 7'h00;
      div_cnt_q <= divisor;
      rate_tick <= 1'b0;
    end else begin                                                          // [R1] [R12]
      rate_tick <= pre_end & div_end;
      pre_cnt_q <= pre_end ? 7'h00 : pre_cnt_q + 7'd1;
      if (pre_end) div_cnt_q <= div_end ? divisor : div_cnt_q - 16'd1;
    end
  end
  assign timer_idle = ~port_en;

  // Sample strobe once per divisor period; reload keeps it aligned after rate changes
  logic samp_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) samp_q <= 1'b0;
    else samp_q <= ~reload & div_end & (pre_cnt_q == 7'(pre_len >> 1));
  end
  assign sample_tick = samp_q;

  // Master clock: one full cycle per rate period, high for its second half, low unless both sync and master are set.
  // Midpoint math relies on the divide-by-four prescale, which sync mode always uses.
  wire [15:0] half_div = 16'((17'(divisor) + 17'd1) >> 1);
  wire        sck_mid  = (div_cnt_q == half_div) && (pre_cnt_q == {5'h00, divisor[0], 1'b1}); // [R7] [R14]
  logic sck_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sck_q <= 1'b0;
    else if (!(mode_sync & mode_master) || reload) sck_q <= 1'b0;
    else if (pre_end & div_end) sck_q <= 1'b0;                             // [R7]
    else if (sck_mid) sck_q <= 1'b1;
  end
  assign sync_clk = sck_q;

  // ==========================================================
  // Receive pin: two flops, then sampler
  logic rx_s1_q;
  logic rx_s2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  wire single = mode_sync | (mode_wide & mode_high);                        // [R3] [R4]

  rgen_sampler u_sampler (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .rx_in       (rx_s2_q),
    .sample_tick (samp_q),
    .single_mode (single),
    .rx_level    (rx_level)
  );

  wire unused_ok = &{1'b0, haddr[31:8], hsize, hwdata[31:8], txsc_rd[0]};
endmodule
`default_nettype wire

/* sim/rgen_monitor.sv */
// Port checker for the rate generator.
// Assumes it is bound onto rgen_top.
`default_nettype none
module rgen_monitor (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rate_tick,
  input wire logic        sample_tick,
  input wire logic        sync_clk,
  input wire logic        rx_level
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Sequences
  sequence unmapped_rd;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h18;
  endsequence
  sequence tick_gap;
    !rate_tick [*3];
  endsequence
  // ==========================================================
  // Properties
  ready_okay_a: assert property (hreadyout && !hresp) else $error("bus wait or error seen");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h000000) else $error("read data upper bits set");
  unmapped_zero_a: assert property (unmapped_rd |=> hrdata == 32'h0) else $error("unmapped read not zero");
  tick_spacing_a: assert property (rate_tick |=> tick_gap) else $error("rate ticks too close");
  // Bus writes may reload the timer between the two
  sample_mid_a: assert property (sample_tick |-> !rate_tick ##[1:70] (rate_tick || hsel))
    else $error("sample tick not inside a period");
  rx_change_a: assert property ($changed(rx_level) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("receive level moved off sample tick");
  // Bus writes may also drop the clock through a reload or a mode change
  sync_fall_a: assert property ($fell(sync_clk) |-> rate_tick || $past(hsel, 2) || $past(hsel, 3))
    else $error("sync clock fell off period end");
  reset_state_a: assert property ($rose(nrst) |-> rx_level && !rate_tick && !sync_clk)
    else $error("outputs not in reset state");
endmodule
bind rgen_top rgen_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .rate_tick(rate_tick), .sample_tick(sample_tick), .sync_clk(sync_clk), .rx_level(rx_level));
`default_nettype wire

/* sim/rgen_tb.sv */
// Self-checking bench for the rate generator.
// Assumes rgen_top, its map header and the bound checker.
`include "rgen_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, nrst, hsel, hwrite, rx_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hreadyout, hresp, rate_tick, sample_tick, sync_clk, rx_level;
  int          fails, comparisons, cyc;
  logic [31:0] rst_tab [7] = '{32'h02, 32'h00, 32'h40, 32'h00, 32'h00, 32'h00, 32'h00};

  rgen_top DUT (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin), .rate_tick(rate_tick),
    .sample_tick(sample_tick), .sync_clk(sync_clk), .rx_level(rx_level));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Bus master: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    cmp(x, e);
  endtask

  task automatic next_tick(output int n, output int k, output int j);
    n = 0;
    k = 0;
    j = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (sync_clk === 1'b1) k++;
      if (sample_tick === 1'b1) j++;
    end while (rate_tick !== 1'b1);
  endtask

  task automatic samples(input int c);
    repeat (c) do @(posedge core_clk); while (sample_tick !== 1'b1);
  endtask

  // Reference period in core_clk cycles
  function automatic int period(int s, int w, int h, int hi, int lo);
    int n;
    int p;
    n = w ? hi * 256 + lo : lo;
    p = s ? 4 : (w && h) ? 4 : (w || h) ? 16 : 64;
    return p * (n + 1);
  endfunction

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    int n, k, j, s, w, h, hi, lo;
    {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'd2;
    rx_pin = 1'b1;
    void'($urandom(66605));
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 7; i++) rd_chk(8'(i * 4), rst_tab[i]);
    wr(8'h18, 32'hff);
    rd_chk(8'h18, 32'h0);
    wr(`RGEN_DIVH_OFF, 32'ha5);
    rd_chk(`RGEN_DIVH_OFF, 32'ha5);
    // ==========================================================
    // Every sync, wide and high speed mode with master set, random divisor and receive level
    for (int m = 0; m < 8; m++) begin
      s = m >> 2;
      w = (m >> 1) & 1;
      h = m & 1;
      hi = $urandom_range(3, 0);
      lo = $urandom_range(15, 0);
      if (w) hi = hi & 1;
      wr(`RGEN_RXSC_OFF, 32'h00);
      wr(`RGEN_TXSC_OFF, 128 + s * 16 + h * 4);
      wr(`RGEN_RATE_OFF, w * 8);
      wr(`RGEN_DIVH_OFF, hi);
      wr(`RGEN_DIVL_OFF, lo);
      wr(`RGEN_RXSC_OFF, 32'h80);
      rx_pin <= 1'($urandom);
      repeat (4) next_tick(n, k, j);
      cmp(n, period(s, w, h, hi, lo));
      cmp(k, s ? period(s, w, h, hi, lo) / 2 : 0);
      cmp(j, 1);
      cmp(rx_level, rx_pin);
      // Flip the pin: after two new samples only the single-sample path follows
      rx_pin <= ~rx_pin;
      repeat (2) @(posedge core_clk);
      samples(2);
      @(posedge core_clk);
      cmp(rx_level, 1'((s || (w && h)) ? rx_pin : !rx_pin));
    end
    // Same-value write right after a tick must restart the count
    wr(`RGEN_TXSC_OFF, 32'h00);
    wr(`RGEN_RATE_OFF, 32'h00);
    wr(`RGEN_DIVL_OFF, 32'h03);
    next_tick(n, k, j);
    wr(`RGEN_DIVL_OFF, 32'h03);
    next_tick(n, k, j);
    cmp(n >= 255 && n <= 258, 1);
    // ==========================================================
    // Mid-run reset returns the registers to their reset values
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk(`RGEN_DIVL_OFF, rst_tab[4]);
    rd_chk(`RGEN_RATE_OFF, rst_tab[2]);
    rd_chk(`RGEN_TXSC_OFF, rst_tab[0]);
    end_of_test();
  end
endmodule
`default_nettype wire
